/* ioev_consts.svh */
// constants for the line event, lock and guard block
`ifndef IOEV_CONSTS_SVH
`define IOEV_CONSTS_SVH

// register select codes, byte offsets on reg_addr
`define IOEV_LINE_OWN_SET 8'h00
`define IOEV_LINE_OWN_CLEAR 8'h04
`define IOEV_DRIVE_ENABLE_SET 8'h10
`define IOEV_DRIVE_ENABLE_CLEAR 8'h14
`define IOEV_FILTER_ON_SET 8'h20
`define IOEV_FILTER_ON_CLEAR 8'h24
`define IOEV_EVENT_MASK_SET 8'h40
`define IOEV_EVENT_MASK_CLEAR 8'h44
`define IOEV_OPEN_DRAIN_SET 8'h50
`define IOEV_OPEN_DRAIN_CLEAR 8'h54
`define IOEV_PULLUP_CLEAR 8'h60
`define IOEV_PULLUP_SET 8'h64
`define IOEV_PERIPH_SELECT_LO 8'h70
`define IOEV_PERIPH_SELECT_HI 8'h74
`define IOEV_PULLDOWN_CLEAR 8'h90
`define IOEV_PULLDOWN_SET 8'h94
`define IOEV_PULLDOWN_STATE 8'h98
`define IOEV_DIRECT_WRITE_SET 8'hA0
`define IOEV_DIRECT_WRITE_CLEAR 8'hA4
`define IOEV_EXTRA_MODE_SET 8'hB0
`define IOEV_EXTRA_MODE_CLEAR 8'hB4
`define IOEV_EDGE_MODE_SET 8'hC0
`define IOEV_LEVEL_MODE_SET 8'hC4
`define IOEV_FALL_LOW_SELECT 8'hD0
`define IOEV_RISE_HIGH_SELECT 8'hD4
`define IOEV_GUARD_MODE 8'hE4
`define IOEV_SCHMITT_WRITE 8'hF0

// guard_mode field layout
`define IOEV_GUARD_EN_BIT 0
`define IOEV_GUARD_KEY_LSB 8
`define IOEV_GUARD_KEY_MSB 31
// access key value is arbitrary
`define IOEV_GUARD_KEY 24'h3C96A5

// reset values
`define IOEV_ZERO_RST 32'h00000000
`define IOEV_ONES_RST 32'hFFFFFFFF
`define IOEV_SRC_RST 8'h00
`endif

/* ioev_detect.sv */
// per-line event detection from two successive samples
`timescale 1ns/1ns
module ioev_detect (
  input wire ioev_pkg::ioev_lines_t cur,
  input wire ioev_pkg::ioev_lines_t prev,
  input wire ioev_pkg::ioev_lines_t extra,
  input wire ioev_pkg::ioev_lines_t level,
  input wire ioev_pkg::ioev_lines_t high,
  output wire ioev_pkg::ioev_lines_t hit
);
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_line
      wire rise = cur[i] & ~prev[i];
      wire fall = ~cur[i] & prev[i];
      wire lvl = high[i] ? cur[i] : ~cur[i];
      wire edg = high[i] ? rise : fall;
      // [RULE_01] four detection types
      // [RULE_22] any edge otherwise
      assign hit[i] = extra[i] ? (level[i] ? lvl : edg) : (rise | fall);
    end
  endgenerate
endmodule // ioev_detect

/* ioev_guard.sv */
// write protection of configuration registers with violation report
`timescale 1ns/1ns
`include "ioev_consts.svh"
module ioev_guard (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire ioev_pkg::ioev_addr_t reg_addr,
  input wire ioev_pkg::ioev_lines_t reg_wdata,
  output wire logic wr_allowed,
  output logic guard_enable_q,
  output logic guard_violation_q,
  output ioev_pkg::ioev_addr_t guard_violation_source_q
);
  wire prot = ioev_pkg::ioev_is_protected(reg_addr);
  wire mode_wr = reg_wr && (reg_addr == `IOEV_GUARD_MODE);
  wire key_ok = reg_wdata[`IOEV_GUARD_KEY_MSB:`IOEV_GUARD_KEY_LSB]
                == `IOEV_GUARD_KEY;
  // [RULE_16] blocked write
  wire blocked = reg_wr && prot && guard_enable_q;
  assign wr_allowed = reg_wr && !blocked;

  // a wrong key leaves the whole mode untouched, so a stray write cannot
  // silently drop protection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      guard_enable_q <= 1'b0;
      guard_violation_q <= 1'b0;
      guard_violation_source_q <= `IOEV_SRC_RST;
    end else begin
      // [RULE_18] keyed clear
      // [RULE_24] wrong key ignored
      if (mode_wr && key_ok) begin
        guard_enable_q <= reg_wdata[`IOEV_GUARD_EN_BIT];
        guard_violation_q <= 1'b0;
      end
      // [RULE_17] flag and source
      // [RULE_25] latest violation
      if (blocked) begin
        guard_violation_q <= 1'b1;
        guard_violation_source_q <= reg_addr;
      end
    end
  end

  property p_guard_flag;
    @(posedge core_clk) disable iff (!resetn)
    blocked |=> guard_violation_q
      && guard_violation_source_q == $past(reg_addr);
  endproperty
  a_guard_flag: assert property (p_guard_flag) // [RULE_17]
    else $error("violation not recorded");

  property p_wrong_key;
    @(posedge core_clk) disable iff (!resetn)
    (mode_wr && !key_ok) |=> $stable(guard_enable_q)
      && (guard_violation_q == $past(guard_violation_q));
  endproperty
  a_wrong_key: assert property (p_wrong_key) // [RULE_24]
    else $error("wrong key changed guard state");

  property p_key_clear;
    @(posedge core_clk) disable iff (!resetn)
    (mode_wr && key_ok) |=> !guard_violation_q
      && guard_enable_q == $past(reg_wdata[`IOEV_GUARD_EN_BIT]);
  endproperty
  a_key_clear: assert property (p_key_clear) // [RULE_18]
    else $error("keyed write did not clear violation");
endmodule // ioev_guard

/* ioev_pin_model.sv */
// far side model: pin levels and peripheral lock requests
`timescale 1ns/1ns
module ioev_pin_model (
  input wire logic core_clk,
  input wire ioev_pkg::ioev_lines_t pin_want,
  input wire ioev_pkg::ioev_lines_t lock_want,
  output ioev_pkg::ioev_lines_t pin_in,
  output ioev_pkg::ioev_lines_t lock_req
);
  // one process drives both; a request lands one cycle late, like a pad
  // stage, and the lines read low from the first edge on
  // pins change freely
  always @(posedge core_clk) begin
    #1;
    pin_in = pin_want;
    lock_req = lock_want;
  end
endmodule // ioev_pin_model

/* ioev_pkg.sv */
// types and shared decode functions for the line event block
`include "ioev_consts.svh"
package ioev_pkg;
  typedef logic [31:0] ioev_lines_t;
  typedef logic [7:0] ioev_addr_t;

  // true for the configuration registers that the guard covers
  function automatic logic ioev_is_protected(input ioev_addr_t a);
    logic r;
    case (a)
      `IOEV_LINE_OWN_SET, `IOEV_LINE_OWN_CLEAR,
      `IOEV_DRIVE_ENABLE_SET, `IOEV_DRIVE_ENABLE_CLEAR,
      `IOEV_FILTER_ON_SET, `IOEV_FILTER_ON_CLEAR,
      `IOEV_OPEN_DRAIN_SET, `IOEV_OPEN_DRAIN_CLEAR,
      `IOEV_PULLUP_CLEAR, `IOEV_PULLUP_SET,
      `IOEV_PERIPH_SELECT_LO, `IOEV_PERIPH_SELECT_HI,
      `IOEV_DIRECT_WRITE_SET, `IOEV_DIRECT_WRITE_CLEAR,
      `IOEV_PULLDOWN_CLEAR, `IOEV_PULLDOWN_STATE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // set or clear the written ones, leaving kept bits alone
  function automatic ioev_lines_t ioev_setclr(input ioev_lines_t q,
    input logic set, input logic clr, input ioev_lines_t data,
    input ioev_lines_t keep);
    ioev_lines_t r;
    r = q;
    if (set) begin
      r = q | (data & ~keep);
    end else if (clr) begin
      r = q & ~(data & ~keep);
    end
    return r;
  endfunction
endpackage

/* ioev_top.sv */
// line event detection, line lock, schmitt control and guarded config
//
// Function
// [RULE_01] extra modes detect rising, falling, low level or high level
// [RULE_02] edge and level set writes choose type, readable per line
// [RULE_03] fall/low and rise/high writes choose polarity, readable per line
// [RULE_04] a detected event sets the line's event flag
// [RULE_05] interrupt asserts when a flag and its mask bit are both set
// [RULE_06] all thirty-two line requests are ORed into one interrupt
// [RULE_07] reading the event flags clears all of them at once
// [RULE_08] a persisting level keeps setting its flag after reads
// [RULE_09] event type resets to edge detection
// [RULE_10] polarity resets to falling edge or low level
// [RULE_11] a peripheral lock input can lock any single line
// [RULE_12] locked bits are ignored in the listed configuration writes
// [RULE_13] lock state is readable at any time
// [RULE_14] only reset clears a lock
// [RULE_15] per-line schmitt trigger, active after reset
// [RULE_16] guard enable makes protected registers reject writes
// [RULE_17] a blocked write sets the violation flag and source
// [RULE_18] violation clears only on guard mode write with correct key
// [RULE_19] protected set covers the listed configuration registers
// [RULE_20] mask set and clear writes update the readable mask
// [RULE_21] extra modes enabled and disabled per line, readable
// [RULE_22] lines without extra modes flag any edge from two samples
// [RULE_23] detection runs whatever the line's configuration
// [RULE_24] a wrong key changes neither guard enable nor violation
// [RULE_25] guard state shows violation flag and latest source
`timescale 1ns/1ns
`include "ioev_consts.svh"
module ioev_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire ioev_pkg::ioev_addr_t reg_addr,
  input wire ioev_pkg::ioev_lines_t reg_wdata,
  input wire logic flags_rd,
  input wire ioev_pkg::ioev_lines_t pin_in,
  input wire ioev_pkg::ioev_lines_t lock_req,
  output logic irq_q,
  output ioev_pkg::ioev_lines_t event_flags_q,
  output ioev_pkg::ioev_lines_t event_mask_state_q,
  output ioev_pkg::ioev_lines_t extra_mode_state_q,
  output ioev_pkg::ioev_lines_t edge_level_state_q,
  output ioev_pkg::ioev_lines_t polarity_state_q,
  output ioev_pkg::ioev_lines_t line_lock_state_q,
  output ioev_pkg::ioev_lines_t schmitt_on_q,
  output ioev_pkg::ioev_lines_t line_own_q,
  output ioev_pkg::ioev_lines_t drive_enable_q,
  output ioev_pkg::ioev_lines_t filter_on_q,
  output ioev_pkg::ioev_lines_t open_drain_q,
  output ioev_pkg::ioev_lines_t pullup_off_q,
  output ioev_pkg::ioev_lines_t periph_select_lo_q,
  output ioev_pkg::ioev_lines_t periph_select_hi_q,
  output ioev_pkg::ioev_lines_t direct_write_q,
  output ioev_pkg::ioev_lines_t pulldown_off_q,
  output logic guard_enable_q,
  output logic guard_violation_q,
  output ioev_pkg::ioev_addr_t guard_violation_source_q
);
  ioev_pkg::ioev_lines_t sample_q;
  ioev_pkg::ioev_lines_t prev_q;
  ioev_pkg::ioev_lines_t hit;
  ioev_pkg::ioev_lines_t flags_d;
  ioev_pkg::ioev_lines_t no_keep;
  ioev_pkg::ioev_lines_t lock_d;
  logic wr_ok;

  // [RULE_16] guard gates writes
  // [RULE_19] protected set decode
  ioev_guard u_guard (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .wr_allowed(wr_ok),
    .guard_enable_q(guard_enable_q),
    .guard_violation_q(guard_violation_q),
    .guard_violation_source_q(guard_violation_source_q)
  );

  // write strobes, one per register select except pulldown state and guard mode
  assign no_keep = `IOEV_ZERO_RST;
  wire w_own_set = wr_ok && reg_addr == `IOEV_LINE_OWN_SET;
  wire w_own_clr = wr_ok && reg_addr == `IOEV_LINE_OWN_CLEAR;
  wire w_drv_set = wr_ok && reg_addr == `IOEV_DRIVE_ENABLE_SET;
  wire w_drv_clr = wr_ok && reg_addr == `IOEV_DRIVE_ENABLE_CLEAR;
  wire w_flt_set = wr_ok && reg_addr == `IOEV_FILTER_ON_SET;
  wire w_flt_clr = wr_ok && reg_addr == `IOEV_FILTER_ON_CLEAR;
  wire w_msk_set = wr_ok && reg_addr == `IOEV_EVENT_MASK_SET;
  wire w_msk_clr = wr_ok && reg_addr == `IOEV_EVENT_MASK_CLEAR;
  wire w_od_set = wr_ok && reg_addr == `IOEV_OPEN_DRAIN_SET;
  wire w_od_clr = wr_ok && reg_addr == `IOEV_OPEN_DRAIN_CLEAR;
  wire w_pu_off = wr_ok && reg_addr == `IOEV_PULLUP_CLEAR;
  wire w_pu_on = wr_ok && reg_addr == `IOEV_PULLUP_SET;
  wire w_sel_lo = wr_ok && reg_addr == `IOEV_PERIPH_SELECT_LO;
  wire w_sel_hi = wr_ok && reg_addr == `IOEV_PERIPH_SELECT_HI;
  wire w_pd_off = wr_ok && reg_addr == `IOEV_PULLDOWN_CLEAR;
  wire w_pd_on = wr_ok && reg_addr == `IOEV_PULLDOWN_SET;
  wire w_dw_set = wr_ok && reg_addr == `IOEV_DIRECT_WRITE_SET;
  wire w_dw_clr = wr_ok && reg_addr == `IOEV_DIRECT_WRITE_CLEAR;
  wire w_ex_set = wr_ok && reg_addr == `IOEV_EXTRA_MODE_SET;
  wire w_ex_clr = wr_ok && reg_addr == `IOEV_EXTRA_MODE_CLEAR;
  wire w_edge = wr_ok && reg_addr == `IOEV_EDGE_MODE_SET;
  wire w_level = wr_ok && reg_addr == `IOEV_LEVEL_MODE_SET;
  wire w_fall = wr_ok && reg_addr == `IOEV_FALL_LOW_SELECT;
  wire w_rise = wr_ok && reg_addr == `IOEV_RISE_HIGH_SELECT;
  wire w_smt = wr_ok && reg_addr == `IOEV_SCHMITT_WRITE;

  // [RULE_11] peripheral lock request
  // [RULE_14] sticky until reset
  assign lock_d = line_lock_state_q | lock_req;

  // [RULE_23] sampled whatever the line's owner or direction
  ioev_detect u_detect (
    .cur(sample_q),
    .prev(prev_q),
    .extra(extra_mode_state_q),
    .level(edge_level_state_q),
    .high(polarity_state_q),
    .hit(hit)
  );

  // [RULE_07] read clears all flags
  // [RULE_08] set beats the read clear
  assign flags_d = (flags_rd ? `IOEV_ZERO_RST : event_flags_q) | hit;

  // input sampling and event flags; pins arrive synchronous already
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sample_q <= `IOEV_ZERO_RST;
      prev_q <= `IOEV_ZERO_RST;
      event_flags_q <= `IOEV_ZERO_RST;
      irq_q <= 1'b0;
      line_lock_state_q <= `IOEV_ZERO_RST;
    end else begin
      sample_q <= pin_in;
      prev_q <= sample_q;
      // [RULE_04] event sets flag
      event_flags_q <= flags_d;
      // [RULE_05] flag and mask
      // [RULE_06] one ORed request
      irq_q <= |(event_flags_q & event_mask_state_q);
      // [RULE_13] lock state readable
      line_lock_state_q <= lock_d;
    end
  end

  // event mode registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      event_mask_state_q <= `IOEV_ZERO_RST;
      extra_mode_state_q <= `IOEV_ZERO_RST;
      // [RULE_09] edge by default
      edge_level_state_q <= `IOEV_ZERO_RST;
      // [RULE_10] fall or low default
      polarity_state_q <= `IOEV_ZERO_RST;
      // [RULE_15] schmitt on at reset
      schmitt_on_q <= `IOEV_ONES_RST;
    end else begin
      // [RULE_20] mask set and clear
      event_mask_state_q <= ioev_pkg::ioev_setclr(event_mask_state_q,
        w_msk_set, w_msk_clr, reg_wdata, no_keep);
      // [RULE_21] extra mode per line
      extra_mode_state_q <= ioev_pkg::ioev_setclr(extra_mode_state_q,
        w_ex_set, w_ex_clr, reg_wdata, no_keep);
      // [RULE_02] edge or level
      edge_level_state_q <= ioev_pkg::ioev_setclr(edge_level_state_q,
        w_level, w_edge, reg_wdata, no_keep);
      // [RULE_03] polarity choice
      polarity_state_q <= ioev_pkg::ioev_setclr(polarity_state_q,
        w_rise, w_fall, reg_wdata, no_keep);
      if (w_smt) begin
        schmitt_on_q <= reg_wdata;
      end
    end
  end

  // line configuration; locking freezes the locked bits of own, open drain, pullup and peripheral select only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      line_own_q <= `IOEV_ONES_RST;
      drive_enable_q <= `IOEV_ZERO_RST;
      filter_on_q <= `IOEV_ZERO_RST;
      open_drain_q <= `IOEV_ZERO_RST;
      pullup_off_q <= `IOEV_ZERO_RST;
      periph_select_lo_q <= `IOEV_ZERO_RST;
      periph_select_hi_q <= `IOEV_ZERO_RST;
      direct_write_q <= `IOEV_ZERO_RST;
      pulldown_off_q <= `IOEV_ONES_RST;
    end else begin
      // [RULE_12] locked bits kept
      line_own_q <= ioev_pkg::ioev_setclr(line_own_q,
        w_own_set, w_own_clr, reg_wdata, line_lock_state_q);
      open_drain_q <= ioev_pkg::ioev_setclr(open_drain_q,
        w_od_set, w_od_clr, reg_wdata, line_lock_state_q);
      pullup_off_q <= ioev_pkg::ioev_setclr(pullup_off_q,
        w_pu_off, w_pu_on, reg_wdata, line_lock_state_q);
      if (w_sel_lo) begin
        periph_select_lo_q <= (periph_select_lo_q & line_lock_state_q)
          | (reg_wdata & ~line_lock_state_q);
      end
      if (w_sel_hi) begin
        periph_select_hi_q <= (periph_select_hi_q & line_lock_state_q)
          | (reg_wdata & ~line_lock_state_q);
      end
      drive_enable_q <= ioev_pkg::ioev_setclr(drive_enable_q,
        w_drv_set, w_drv_clr, reg_wdata, no_keep);
      filter_on_q <= ioev_pkg::ioev_setclr(filter_on_q,
        w_flt_set, w_flt_clr, reg_wdata, no_keep);
      direct_write_q <= ioev_pkg::ioev_setclr(direct_write_q,
        w_dw_set, w_dw_clr, reg_wdata, no_keep);
      pulldown_off_q <= ioev_pkg::ioev_setclr(pulldown_off_q,
        w_pd_off, w_pd_on, reg_wdata, no_keep);
    end
  end

  // checks
  sequence s_event;
    |hit;
  endsequence

  sequence s_flags_hold_hit;
    (event_flags_q & $past(hit)) == $past(hit);
  endsequence

  property p_event_sets;
    @(posedge core_clk) disable iff (!resetn)
    s_event |=> s_flags_hold_hit;
  endproperty
  a_event_sets: assert property (p_event_sets) // [RULE_04]
    else $error("event did not set its flag");

  property p_read_clear;
    @(posedge core_clk) disable iff (!resetn)
    (flags_rd && hit == `IOEV_ZERO_RST) |=> event_flags_q == `IOEV_ZERO_RST;
  endproperty
  a_read_clear: assert property (p_read_clear) // [RULE_07]
    else $error("read did not clear flags");

  property p_level_persist;
    @(posedge core_clk) disable iff (!resetn)
    (flags_rd ##0 s_event) |=> s_flags_hold_hit;
  endproperty
  a_level_persist: assert property (p_level_persist) // [RULE_08]
    else $error("event lost in read cycle");

  property p_irq;
    @(posedge core_clk) disable iff (!resetn)
    (|(event_flags_q & event_mask_state_q)) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) // [RULE_05]
    else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge core_clk) disable iff (!resetn)
    !(|(event_flags_q & event_mask_state_q)) |=> !irq_q;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) // [RULE_06]
    else $error("interrupt without masked flag");

  property p_lock_sticky;
    @(posedge core_clk) disable iff (!resetn)
    1'b1 |=> (line_lock_state_q & $past(line_lock_state_q | lock_req))
      == $past(line_lock_state_q | lock_req);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) // [RULE_14]
    else $error("lock lost or not taken");

  property p_lock_guard;
    @(posedge core_clk) disable iff (!resetn)
    (w_own_set || w_own_clr) |=> ((line_own_q ^ $past(line_own_q))
      & $past(line_lock_state_q)) == `IOEV_ZERO_RST;
  endproperty
  a_lock_guard: assert property (p_lock_guard) // [RULE_12]
    else $error("locked line changed");

  property p_guard_block;
    @(posedge core_clk) disable iff (!resetn)
    (reg_wr && guard_enable_q && reg_addr == `IOEV_DRIVE_ENABLE_SET)
      |=> $stable(drive_enable_q);
  endproperty
  a_guard_block: assert property (p_guard_block) // [RULE_16]
    else $error("protected write took effect");

  property p_mask_set;
    @(posedge core_clk) disable iff (!resetn)
    w_msk_set |=> (event_mask_state_q & $past(reg_wdata))
      == $past(reg_wdata);
  endproperty
  a_mask_set: assert property (p_mask_set) // [RULE_20]
    else $error("mask bits not set");
endmodule // ioev_top

/* testbench.sv */
// self-checking bench for the line event, lock and guard block
`timescale 1ns/1ns
`include "ioev_consts.svh"
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic flags_rd = 1'b0;
  ioev_pkg::ioev_addr_t reg_addr = 8'h00;
  ioev_pkg::ioev_lines_t reg_wdata = 32'h00000000;
  ioev_pkg::ioev_lines_t pin_want = 32'h00000000;
  ioev_pkg::ioev_lines_t lock_want = 32'h00000000;
  ioev_pkg::ioev_lines_t pin_in, lock_req;
  logic irq_q, guard_enable_q, guard_violation_q;
  ioev_pkg::ioev_addr_t guard_violation_source_q;
  ioev_pkg::ioev_lines_t event_flags_q, event_mask_state_q;
  ioev_pkg::ioev_lines_t extra_mode_state_q, edge_level_state_q;
  ioev_pkg::ioev_lines_t polarity_state_q, line_lock_state_q;
  ioev_pkg::ioev_lines_t schmitt_on_q, line_own_q, drive_enable_q;
  ioev_pkg::ioev_lines_t filter_on_q, open_drain_q, pullup_off_q;
  ioev_pkg::ioev_lines_t periph_select_lo_q, periph_select_hi_q;
  ioev_pkg::ioev_lines_t direct_write_q, pulldown_off_q;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h8CB01230;
  logic [31:0] pin_now = 32'h00000000;
  logic [31:0] x_m, l_m, h_m, m_m;
  logic [287:0] cfg_snap;
  wire [287:0] cfg_all = {line_own_q, drive_enable_q, filter_on_q,
    open_drain_q, pullup_off_q, periph_select_lo_q, periph_select_hi_q,
    direct_write_q, pulldown_off_q};
  ioev_pkg::ioev_addr_t prot [16] = '{`IOEV_LINE_OWN_SET,
    `IOEV_LINE_OWN_CLEAR, `IOEV_DRIVE_ENABLE_SET, `IOEV_DRIVE_ENABLE_CLEAR,
    `IOEV_FILTER_ON_SET, `IOEV_FILTER_ON_CLEAR, `IOEV_OPEN_DRAIN_SET,
    `IOEV_OPEN_DRAIN_CLEAR, `IOEV_PULLUP_CLEAR, `IOEV_PULLUP_SET,
    `IOEV_PERIPH_SELECT_LO, `IOEV_PERIPH_SELECT_HI, `IOEV_DIRECT_WRITE_SET,
    `IOEV_DIRECT_WRITE_CLEAR, `IOEV_PULLDOWN_CLEAR, `IOEV_PULLDOWN_STATE};

  ioev_top DUT (.core_clk, .resetn, .reg_wr, .reg_addr, .reg_wdata,
    .flags_rd, .pin_in, .lock_req, .irq_q, .event_flags_q,
    .event_mask_state_q, .extra_mode_state_q, .edge_level_state_q,
    .polarity_state_q, .line_lock_state_q, .schmitt_on_q, .line_own_q,
    .drive_enable_q, .filter_on_q, .open_drain_q, .pullup_off_q,
    .periph_select_lo_q, .periph_select_hi_q, .direct_write_q,
    .pulldown_off_q, .guard_enable_q, .guard_violation_q,
    .guard_violation_source_q);

  ioev_pin_model far_side (.core_clk(core_clk), .pin_want(pin_want),
    .lock_want(lock_want), .pin_in(pin_in), .lock_req(lock_req));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  // drive point is 1 ns after the edge so no race with the design
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // idle cycle first so the strobe never toggles twice in one step
  task automatic wr(input ioev_pkg::ioev_addr_t a, input logic [31:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // level hits for sample s under extra, level and high masks
  function automatic logic [31:0] lvl(input logic [31:0] s, x, l, h);
    return x & l & ((h & s) | (~h & ~s));
  endfunction

  // edge hits from previous p to current v
  function automatic logic [31:0] edg(input logic [31:0] p, v, x, l, h);
    return (~x & (p ^ v)) | (x & ~l & ((h & ~p & v) | (~h & p & ~v)));
  endfunction

  // move the pins, let the event settle, then read and check flags
  task automatic step(input logic [31:0] v);
    logic [31:0] e;
    e = edg(pin_now, v, x_m, l_m, h_m) | lvl(pin_now, x_m, l_m, h_m)
      | lvl(v, x_m, l_m, h_m);
    pin_want = v;
    repeat (5) tick();
    flags_rd = 1'b1;
    chk("event_flags", e, event_flags_q);
    chk("irq", {31'h0, |(e & m_m)}, {31'h0, irq_q});
    tick();
    flags_rd = 1'b0;
    pin_now = v;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    x_m = 32'h00000000;
    l_m = 32'h00000000;
    h_m = 32'h00000000;
    repeat (2) tick();
    resetn = 1'b1;
    // reset values of the state outputs
    chk("edge_level", 32'h00000000, edge_level_state_q);
    chk("polarity", 32'h00000000, polarity_state_q);
    chk("schmitt", 32'hFFFFFFFF, schmitt_on_q);
    chk("lock", 32'h00000000, line_lock_state_q);
    chk("pulldown_off", 32'hFFFFFFFF, pulldown_off_q);
    chk("line_own", 32'hFFFFFFFF, line_own_q);
    seed = xs(seed);
    m_m = seed;
    wr(`IOEV_EVENT_MASK_SET, m_m);
    seed = xs(seed);
    wr(`IOEV_EVENT_MASK_CLEAR, seed);
    m_m = m_m & ~seed;
    chk("mask", m_m, event_mask_state_q);
    seed = xs(seed);
    wr(`IOEV_SCHMITT_WRITE, seed);
    chk("schmitt", seed, schmitt_on_q);
    // any-edge events on random pin patterns
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      step(seed);
    end
    // all four extra modes on lines 0 to 7, mid config changes ignored
    wr(`IOEV_EXTRA_MODE_SET, 32'h000001FF);
    wr(`IOEV_EXTRA_MODE_CLEAR, 32'h00000100);
    wr(`IOEV_LEVEL_MODE_SET, 32'h00000038);
    wr(`IOEV_EDGE_MODE_SET, 32'h000000C7);
    wr(`IOEV_RISE_HIGH_SELECT, 32'h000000FF);
    wr(`IOEV_FALL_LOW_SELECT, 32'h0000004A);
    x_m = 32'h000000FF;
    l_m = 32'h00000038;
    h_m = 32'h000000B5;
    chk("extra_mode", x_m, extra_mode_state_q);
    chk("edge_level", l_m, edge_level_state_q);
    chk("polarity", h_m, polarity_state_q);
    repeat (2) tick();
    flags_rd = 1'b1;
    tick();
    flags_rd = 1'b0;
    step(32'h00000000);
    step(32'h00000000);
    step(32'hFFFFFFFF);
    step(32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      step(seed);
    end
    // lock a random set of lines, then try to rewrite them
    seed = xs(seed);
    lock_want = seed;
    repeat (3) tick();
    chk("lock", seed, line_lock_state_q);
    wr(`IOEV_LINE_OWN_CLEAR, 32'hFFFFFFFF);
    chk("line_own", seed, line_own_q);
    wr(`IOEV_OPEN_DRAIN_SET, 32'hFFFFFFFF);
    chk("open_drain", ~seed, open_drain_q);
    wr(`IOEV_PULLUP_CLEAR, 32'hFFFFFFFF);
    chk("pullup_off", ~seed, pullup_off_q);
    wr(`IOEV_PERIPH_SELECT_HI, 32'hFFFFFFFF);
    chk("periph_hi", ~seed, periph_select_hi_q);
    wr(`IOEV_PERIPH_SELECT_LO, 32'hFFFFFFFF);
    chk("periph_lo", ~seed, periph_select_lo_q);
    wr(`IOEV_PULLUP_SET, 32'hFFFFFFFF);
    chk("pullup_off", 32'h00000000, pullup_off_q);
    wr(`IOEV_OPEN_DRAIN_CLEAR, 32'hFFFFFFFF);
    chk("open_drain", 32'h00000000, open_drain_q);
    wr(`IOEV_LINE_OWN_SET, 32'hFFFFFFFF);
    chk("line_own", 32'hFFFFFFFF, line_own_q);
    wr(`IOEV_DRIVE_ENABLE_SET, 32'hFFFFFFFF);
    chk("drive_enable", 32'hFFFFFFFF, drive_enable_q);
    // registers outside the lock list take every written bit
    wr(`IOEV_DRIVE_ENABLE_CLEAR, 32'hF0F0F0F0);
    chk("drive_enable", 32'h0F0F0F0F, drive_enable_q);
    wr(`IOEV_FILTER_ON_SET, 32'h0000FFFF);
    wr(`IOEV_FILTER_ON_CLEAR, 32'h00FF00FF);
    chk("filter_on", 32'h0000FF00, filter_on_q);
    wr(`IOEV_DIRECT_WRITE_SET, 32'h00FF00FF);
    wr(`IOEV_DIRECT_WRITE_CLEAR, 32'h000000FF);
    chk("direct_write", 32'h00FF0000, direct_write_q);
    wr(`IOEV_PULLDOWN_SET, 32'h0000FFFF);
    wr(`IOEV_PULLDOWN_CLEAR, 32'h000000FF);
    chk("pulldown_off", 32'hFFFF00FF, pulldown_off_q);
    lock_want = 32'h00000000;
    repeat (3) tick();
    chk("lock_kept", seed, line_lock_state_q);
    // guard on, then every covered register is refused and reported
    wr(`IOEV_GUARD_MODE, {`IOEV_GUARD_KEY, 8'h01});
    chk("guard_en", 32'h1, {31'h0, guard_enable_q});
    foreach (prot[i]) begin
      cfg_snap = cfg_all;
      seed = xs(seed);
      wr(prot[i], seed);
      chk("cfg_changed", 32'h0, {31'h0, cfg_all !== cfg_snap});
      chk("violation", 32'h1, {31'h0, guard_violation_q});
      chk("source", {24'h0, prot[i]},
        {24'h0, guard_violation_source_q});
      wr(`IOEV_GUARD_MODE, {(`IOEV_GUARD_KEY ^ 24'h000001), 8'h00});
      chk("guard_en", 32'h1, {31'h0, guard_enable_q});
      chk("violation", 32'h1, {31'h0, guard_violation_q});
      wr(`IOEV_GUARD_MODE, {`IOEV_GUARD_KEY, 8'h01});
      chk("violation", 32'h0, {31'h0, guard_violation_q});
    end
    // a register outside the covered set still takes writes
    wr(`IOEV_EVENT_MASK_SET, 32'hFFFFFFFF);
    chk("mask", 32'hFFFFFFFF, event_mask_state_q);
    chk("violation", 32'h0, {31'h0, guard_violation_q});
    wr(`IOEV_GUARD_MODE, {`IOEV_GUARD_KEY, 8'h00});
    chk("guard_en", 32'h0, {31'h0, guard_enable_q});
    // only a reset drops the locks
    resetn = 1'b0;
    tick();
    resetn = 1'b1;
    chk("lock_reset", 32'h00000000, line_lock_state_q);
    complete_run();
  end
endmodule // testbench
